// ==== lbf_pkg.sv ====
// Shared constants for the LED backlight fade and blink controller.
package lbf_pkg;
   localparam int CLK_MHZ = 200;
   localparam int NCH = 5;
   localparam int NBLK = 3;
   localparam int CODE_W = 6;
   localparam int RATE_W = 4;
   localparam int OVP_W = 2;
   localparam int RAMP_W = 8;
   localparam int UA_W = 15;
   localparam int FADE_CNT_W = 24;
   localparam int BLINK_CNT_W = 32;
   localparam int PG_CNT_W = 20;
   localparam int SS_CNT_W = 16;
   // Boost mode select value for standalone operation.
   localparam logic MODE_STANDALONE = 1'h1;
   // Power-good deglitch time.
   localparam int DEGLITCH_MS = 2;
   localparam int DEGLITCH_CYC = DEGLITCH_MS * CLK_MHZ * 1000;
   // Soft-start time, split into equal ramp steps.
   localparam int SOFT_START_MS = 1;
   localparam int SOFT_START_CYC = SOFT_START_MS * CLK_MHZ * 1000;
   localparam int RAMP_STEPS = 256;
   localparam int SS_STEP_CYC = SOFT_START_CYC / RAMP_STEPS;
   localparam logic [RAMP_W-1:0] RAMP_FULL = 8'hFF;
   // Fade rates are tenths of a second; a full swing spans FULL_CODE steps.
   localparam int FADE_TICK_MS = 100;
   localparam int FULL_CODE = 63;
   localparam int FADE_UNIT_CYC = FADE_TICK_MS * CLK_MHZ * 1000 / FULL_CODE;
   localparam logic [RATE_W-1:0] FADE_OFF = 4'h0;
   // Blink timer unit.
   localparam int BLINK_UNIT_MS = 100;
   localparam int BLINK_UNIT_CYC = BLINK_UNIT_MS * CLK_MHZ * 1000;
   localparam logic [RATE_W-1:0] BLINK_OFF = 4'h0;
   // Full-scale sink current in microamps.
   localparam int FULL_SCALE_UA = 20000;
   localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00;
endpackage

// ==== lbf_top.sv ====
// Boost activation, power-good, soft-start, backlight fading and blink control.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Mode select 1 runs boost standalone at a fixed divider-set output.
// - Standalone mode forces every LED sink off whatever the enables say.
// - Standalone boost on/off follows the boost enable bit only.
// - LED mode turns boost on when any sink is active; enable bit ignored.
// - A four-level overvoltage select is passed on in both modes.
// - Power-good pin shows boost good only in standalone mode with mask set.
// - Boost good rises after 2 ms of good feedback, drops at once on trip.
// - Boost good state is exposed as a readable status bit.
// - Boost start-up ramps its target over a fixed 1 ms soft start.
// - Backlight current comes from a 6-bit code, 64 levels to full scale.
// - Current is full scale times code squared over 63 squared.
// - Backlight enable 1 turns the backlight on, 0 turns it off.
// - Four-bit fade-in/out rates; code 0 disables fading, others 0.3 to 4.5 s.
// - Fade time scales with code change: rate times code over 63.
// - Override bit plus enable rewrite mid-fade jumps straight to target.
// - Grouped channels 2 to 5 follow channel 1 code and on/off.
// - Ungrouped channels use their own code and enable.
// - Ungrouped channels 3 to 5 blink when off timer is nonzero.
// - Blinking channels still fade but ignore the fade override.
// - Blinkers enabled by one write start their on periods together.
module lbf_top #(
   parameter int DEGLITCH_CYC = lbf_pkg::DEGLITCH_CYC,
   parameter int SS_STEP_CYC = lbf_pkg::SS_STEP_CYC,
   parameter int FADE_UNIT_CYC = lbf_pkg::FADE_UNIT_CYC,
   parameter int BLINK_UNIT_CYC = lbf_pkg::BLINK_UNIT_CYC
) (
   input wire logic CLK_IN, // 200 MHz timebase.
   input wire logic SYS_RST_IN, // Synchronous reset, active high.
   input wire logic BOOST_MODE_SELECT_IN, // 1 standalone, 0 LED mode.
   input wire logic BOOST_STANDALONE_ENABLE_IN, // Boost enable for standalone.
   input wire logic [1:0] BOOST_OVERVOLTAGE_SELECT_IN, // Overvoltage level code.
   input wire logic BOOST_GOOD_ROUTE_MASK_IN, // Route boost good to pin.
   input wire logic FB_GOOD_RISE_IN, // Feedback above rising threshold.
   input wire logic FB_LOW_FALL_IN, // Feedback below falling threshold.
   input wire logic [5:0] BACKLIGHT_CURRENT_CODE_IN, // Backlight code.
   input wire logic BACKLIGHT_ENABLE_IN, // Backlight on/off.
   input wire logic BACKLIGHT_ENABLE_WR_IN, // Pulse: enable bit written.
   input wire logic [3:0] FADE_IN_RATE_IN, // Fade-in rate code.
   input wire logic [3:0] FADE_OUT_RATE_IN, // Fade-out rate code.
   input wire logic FADE_OVERRIDE_ENABLE_IN, // Fade override.
   input wire logic [3:0] CHANNEL_GROUP_SELECT_IN, // Group bits, ch2..ch5.
   input wire logic [3:0] LED_CHANNEL_ENABLE_IN, // Sink enables, ch2..ch5.
   input wire logic LED_CHANNEL_ENABLE_WR_IN, // Pulse: sink enables written.
   input wire logic [23:0] CHANNEL_CODE_IN, // Own codes, ch2..ch5.
   input wire logic [11:0] BLINK_ON_TIMER_IN, // On timers, ch3..ch5.
   input wire logic [11:0] BLINK_OFF_TIMER_IN, // Off timers, ch3..ch5.
   output logic BOOST_ON_OUT, // Boost running.
   output logic BOOST_SOFT_START_OUT, // Soft start in progress.
   output logic [7:0] BOOST_RAMP_OUT, // Soft-start target ramp.
   output logic [1:0] BOOST_OVP_SEL_OUT, // Overvoltage level to regulator.
   output logic BOOST_GOOD_STATUS_OUT, // Boost good status bit.
   output logic POWER_GOOD_PIN_OUT, // External power-good pin.
   output logic [29:0] SINK_LEVEL_OUT, // Applied codes, ch1..ch5.
   output logic [74:0] SINK_CURRENT_UA_OUT, // Sink currents in uA, ch1..ch5.
   output logic [2:0] BLINK_ACTIVE_OUT // Blink mode, ch3..ch5.
);

   // Fade duration of a full swing in tenths of a second; unlisted codes act as 4.5 s.
   function automatic logic [5:0] fade_tenths(input logic [3:0] rate);
      case (rate)
         4'h0: fade_tenths = 6'h00;
         4'h1: fade_tenths = 6'h03;
         4'h2: fade_tenths = 6'h06;
         4'h3: fade_tenths = 6'h06;
         4'h4: fade_tenths = 6'h06;
         4'h5: fade_tenths = 6'h09;
         4'h6: fade_tenths = 6'h0C;
         4'h7: fade_tenths = 6'h15;
         4'h8: fade_tenths = 6'h18;
         4'h9: fade_tenths = 6'h1B;
         4'hA: fade_tenths = 6'h1E;
         4'hB: fade_tenths = 6'h21;
         4'hC: fade_tenths = 6'h24;
         4'hD: fade_tenths = 6'h27;
         4'hE: fade_tenths = 6'h2A;
         default: fade_tenths = 6'h2D;
      endcase
   endfunction

   // Square-law current in microamps for a code.
   function automatic logic [14:0] square_ua(input logic [5:0] code);
      logic [31:0] prod;
      prod = 32'(lbf_pkg::FULL_SCALE_UA) * 32'(code) * 32'(code);
      square_ua = 15'(prod / 32'(lbf_pkg::FULL_CODE * lbf_pkg::FULL_CODE));
   endfunction

   typedef enum logic [1:0] {LBF_SS_IDLE, LBF_SS_RAMP, LBF_SS_DONE} lbf_ss_e;

   logic standalone;
   logic [4:0] grp5;
   logic [4:0] en5;
   logic [29:0] code5;
   logic [4:0] blink_dark5;
   assign standalone = (BOOST_MODE_SELECT_IN == lbf_pkg::MODE_STANDALONE);
   assign grp5 = {CHANNEL_GROUP_SELECT_IN, 1'h0};
   assign en5 = {LED_CHANNEL_ENABLE_IN, BACKLIGHT_ENABLE_IN};
   assign code5 = {CHANNEL_CODE_IN, BACKLIGHT_CURRENT_CODE_IN};

   // Blink state for ch3..ch5.
   logic [2:0] blink_act;
   logic [2:0] phase_on_r, phase_on_nxt;
   logic [lbf_pkg::BLINK_CNT_W-1:0] bcnt_r [lbf_pkg::NBLK];
   logic [lbf_pkg::BLINK_CNT_W-1:0] bcnt_nxt [lbf_pkg::NBLK];
   logic [lbf_pkg::BLINK_CNT_W-1:0] blim [lbf_pkg::NBLK];
   logic [3:0] en_prev_r;
   logic [3:0] btime [lbf_pkg::NBLK];
   logic [2:0] bstart;

   // Blink timers; a write that newly enables several blinkers restarts them together.
   always_comb begin
      for (int j = 0; j < lbf_pkg::NBLK; j++) begin
         blink_act[j] = ~grp5[j+2] &
            (BLINK_OFF_TIMER_IN[4*j +: 4] != lbf_pkg::BLINK_OFF);
         bstart[j] = LED_CHANNEL_ENABLE_WR_IN & en5[j+2] & ~en_prev_r[j+1];
         btime[j] = phase_on_r[j] ? BLINK_ON_TIMER_IN[4*j +: 4] : BLINK_OFF_TIMER_IN[4*j +: 4];
         if (btime[j] == 4'h0) begin
            btime[j] = 4'h1; // A zero on time still lights for one unit.
         end
         blim[j] = 32'(btime[j]) * 32'(BLINK_UNIT_CYC);
         phase_on_nxt[j] = phase_on_r[j];
         bcnt_nxt[j] = bcnt_r[j] + 32'h1;
         if (!blink_act[j] || bstart[j]) begin
            phase_on_nxt[j] = 1'h1;
            bcnt_nxt[j] = '0;
         end else if (bcnt_r[j] >= blim[j] - 32'h1) begin
            phase_on_nxt[j] = ~phase_on_r[j];
            bcnt_nxt[j] = '0;
         end
      end
      blink_dark5 = {blink_act & ~phase_on_r, 2'h0};
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         phase_on_r <= 3'h7;
         en_prev_r <= 4'h0;
         for (int j = 0; j < lbf_pkg::NBLK; j++) begin
            bcnt_r[j] <= '0;
         end
      end else begin
         phase_on_r <= phase_on_nxt;
         en_prev_r <= LED_CHANNEL_ENABLE_IN;
         for (int j = 0; j < lbf_pkg::NBLK; j++) begin
            bcnt_r[j] <= bcnt_nxt[j];
         end
      end
   end

   // Fade engines, one per channel.
   logic [5:0] level_r [lbf_pkg::NCH];
   logic [5:0] level_nxt [lbf_pkg::NCH];
   logic [5:0] tgt [lbf_pkg::NCH];
   logic [3:0] rate [lbf_pkg::NCH];
   logic [23:0] per [lbf_pkg::NCH];
   logic [23:0] fcnt_r [lbf_pkg::NCH];
   logic [23:0] fcnt_nxt [lbf_pkg::NCH];
   logic [14:0] ua_r [lbf_pkg::NCH];
   logic ovr_jump, fade_busy_r, fade_busy_nxt;
   assign ovr_jump = FADE_OVERRIDE_ENABLE_IN & BACKLIGHT_ENABLE_WR_IN & fade_busy_r;

   // Grouped channels copy channel 1; others step toward their own target, or jump to it when their rate is 0 or, for channel 1 only, on an override.
   always_comb begin
      for (int i = 0; i < lbf_pkg::NCH; i++) begin
         tgt[i] = (en5[i] & ~blink_dark5[i]) ? code5[6*i +: 6] : lbf_pkg::CODE_ZERO;
         rate[i] = (tgt[i] > level_r[i]) ? FADE_IN_RATE_IN : FADE_OUT_RATE_IN;
         per[i] = 24'(32'(fade_tenths(rate[i])) * 32'(FADE_UNIT_CYC));
         level_nxt[i] = level_r[i];
         fcnt_nxt[i] = fcnt_r[i] + 24'h1;
         if (standalone) begin
            level_nxt[i] = lbf_pkg::CODE_ZERO;
            fcnt_nxt[i] = '0;
         end else if (grp5[i]) begin
            level_nxt[i] = level_nxt[0];
            fcnt_nxt[i] = '0;
         end else if (rate[i] == lbf_pkg::FADE_OFF || (i == 0 && ovr_jump)) begin
            level_nxt[i] = tgt[i];
            fcnt_nxt[i] = '0;
         end else if (level_r[i] == tgt[i]) begin
            fcnt_nxt[i] = '0;
         end else if (fcnt_r[i] >= per[i] - 24'h1) begin
            fcnt_nxt[i] = '0;
            level_nxt[i] = (tgt[i] > level_r[i]) ? level_r[i] + 6'h1 : level_r[i] - 6'h1;
         end
      end
      fade_busy_nxt = !standalone && (level_nxt[0] != tgt[0]); // Only a running fade is overridden.
   end

   always_ff @(posedge CLK_IN) begin
      for (int i = 0; i < lbf_pkg::NCH; i++) begin
         if (SYS_RST_IN) begin
            level_r[i] <= lbf_pkg::CODE_ZERO;
            fcnt_r[i] <= '0;
            ua_r[i] <= '0;
         end else begin
            level_r[i] <= level_nxt[i];
            fcnt_r[i] <= fcnt_nxt[i];
            ua_r[i] <= square_ua(level_nxt[i]);
         end
      end
      fade_busy_r <= SYS_RST_IN ? 1'h0 : fade_busy_nxt;
   end

   // Flatten per-channel flops onto the output buses.
   for (genvar g = 0; g < lbf_pkg::NCH; g++) begin : g_out
      assign SINK_LEVEL_OUT[6*g +: 6] = level_r[g];
      assign SINK_CURRENT_UA_OUT[15*g +: 15] = ua_r[g];
   end

   // Boost enable, soft start and power-good.
   logic any_active;
   logic boost_on_r, boost_on_nxt;
   lbf_ss_e ss_r, ss_nxt;
   logic [15:0] sscnt_r, sscnt_nxt;
   logic [7:0] ramp_r, ramp_nxt;
   logic [19:0] pgcnt_r, pgcnt_nxt;
   logic pg_r, pg_nxt;
   logic pin_r, pin_nxt, ss_on_r, ss_on_nxt;
   logic [1:0] ovp_r;
   logic [2:0] bact_r;

   always_comb begin
      any_active = 1'h0;
      for (int i = 0; i < lbf_pkg::NCH; i++) begin
         any_active = any_active | (level_r[i] != lbf_pkg::CODE_ZERO);
      end
      // Standalone listens to the enable bit only; LED mode to active sinks only.
      boost_on_nxt = standalone ? BOOST_STANDALONE_ENABLE_IN : any_active;
      ss_nxt = ss_r;
      sscnt_nxt = sscnt_r;
      ramp_nxt = ramp_r;
      case (ss_r)
         LBF_SS_IDLE: begin
            ramp_nxt = '0;
            sscnt_nxt = '0;
            if (boost_on_r) begin
               ss_nxt = LBF_SS_RAMP;
            end
         end
         LBF_SS_RAMP: begin
            if (sscnt_r >= 16'(SS_STEP_CYC - 1)) begin
               sscnt_nxt = '0;
               ramp_nxt = ramp_r + 8'h1;
               if (ramp_r == lbf_pkg::RAMP_FULL - 8'h1) begin
                  ss_nxt = LBF_SS_DONE;
               end
            end else begin
               sscnt_nxt = sscnt_r + 16'h1;
            end
         end
         LBF_SS_DONE: begin
            ramp_nxt = lbf_pkg::RAMP_FULL;
         end
         default: begin
            ss_nxt = LBF_SS_IDLE;
         end
      endcase
      // Turning the boost off restarts the ramp from zero next time.
      if (!boost_on_r) begin
         ss_nxt = LBF_SS_IDLE;
         ramp_nxt = '0;
         sscnt_nxt = '0;
      end
      // Falling trip wins over the deglitch count so the drop is immediate.
      pg_nxt = pg_r;
      pgcnt_nxt = '0;
      if (FB_LOW_FALL_IN || !boost_on_r) begin
         pg_nxt = 1'h0;
      end else if (FB_GOOD_RISE_IN && !pg_r) begin
         if (pgcnt_r >= 20'(DEGLITCH_CYC - 1)) begin
            pg_nxt = 1'h1;
         end else begin
            pgcnt_nxt = pgcnt_r + 20'h1;
         end
      end
      pin_nxt = standalone & BOOST_GOOD_ROUTE_MASK_IN & pg_nxt;
      ss_on_nxt = (ss_nxt == LBF_SS_RAMP);
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         boost_on_r <= 1'h0;
         ss_r <= LBF_SS_IDLE;
         sscnt_r <= '0;
         ramp_r <= '0;
         pgcnt_r <= '0;
         pg_r <= 1'h0;
         pin_r <= 1'h0;
         ss_on_r <= 1'h0;
         ovp_r <= '0;
         bact_r <= '0;
      end else begin
         boost_on_r <= boost_on_nxt;
         ss_r <= ss_nxt;
         sscnt_r <= sscnt_nxt;
         ramp_r <= ramp_nxt;
         pgcnt_r <= pgcnt_nxt;
         pg_r <= pg_nxt;
         pin_r <= pin_nxt;
         ss_on_r <= ss_on_nxt;
         ovp_r <= BOOST_OVERVOLTAGE_SELECT_IN;
         bact_r <= blink_act;
      end
   end

   assign BOOST_ON_OUT = boost_on_r;
   assign BOOST_SOFT_START_OUT = ss_on_r;
   assign BOOST_RAMP_OUT = ramp_r;
   assign BOOST_OVP_SEL_OUT = ovp_r;
   assign BOOST_GOOD_STATUS_OUT = pg_r;
   assign POWER_GOOD_PIN_OUT = pin_r;
   assign BLINK_ACTIVE_OUT = bact_r;

   // Checks on the relations between causes and outputs.
   sequence seq_ovr_write;
      !standalone && ovr_jump;
   endsequence
   sequence seq_boost_start;
      !boost_on_r ##1 boost_on_r;
   endsequence

   AST_STANDALONE_DARK: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      standalone |=> SINK_LEVEL_OUT == 30'h0)
      else $error("sink lit in standalone mode");
   AST_BOOST_STANDALONE: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      standalone |=> BOOST_ON_OUT == $past(BOOST_STANDALONE_ENABLE_IN))
      else $error("standalone boost not following enable");
   AST_BOOST_LED: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !standalone |=> BOOST_ON_OUT == $past(any_active))
      else $error("LED mode boost not following sinks");
   AST_PG_DROP: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      FB_LOW_FALL_IN |=> !BOOST_GOOD_STATUS_OUT && !POWER_GOOD_PIN_OUT)
      else $error("power good held after falling trip");
   AST_PG_RISE: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      $rose(BOOST_GOOD_STATUS_OUT) |-> $past(pgcnt_r) == 20'(DEGLITCH_CYC - 1))
      else $error("power good rose without full deglitch");
   AST_PIN_ROUTE: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      POWER_GOOD_PIN_OUT == ($past(standalone) && $past(BOOST_GOOD_ROUTE_MASK_IN) &&
         BOOST_GOOD_STATUS_OUT))
      else $error("power good pin routing wrong");
   AST_SOFT_START: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      seq_boost_start ##1 boost_on_r [*8] |=> BOOST_SOFT_START_OUT)
      else $error("soft start too short");
   AST_OVERRIDE: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      seq_ovr_write |=> level_r[0] == $past(tgt[0]))
      else $error("override did not jump to target");
   AST_FADE_STEP: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (!standalone && !ovr_jump && rate[0] != lbf_pkg::FADE_OFF) |=>
         (level_r[0] - $past(level_r[0]) == 6'h1 || $past(level_r[0]) - level_r[0] == 6'h1 ||
          level_r[0] == $past(level_r[0])))
      else $error("fade moved more than one step");
   AST_GROUP_FOLLOW: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (!standalone && grp5[1]) |=> level_r[1] == level_r[0])
      else $error("grouped channel not following channel 1");
   AST_BLINK_SYNC: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (bstart[0] && bstart[1]) |=> (bcnt_r[0] == bcnt_r[1] && phase_on_r[0] && phase_on_r[1]))
      else $error("blinkers enabled together not aligned");
   AST_SQUARE_LAW: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      level_r[0] == 6'h3F |-> ua_r[0] == 15'(lbf_pkg::FULL_SCALE_UA))
      else $error("full code not at full scale");

endmodule
`default_nettype wire

// ==== lbf_fb_model.sv ====
// Feedback comparator model for the boost output sensed through its divider.
`timescale 1ns/10ps
`default_nettype none
module lbf_fb_model (
   input wire logic boost_on_in, // Boost running.
   input wire logic [7:0] ramp_in, // Soft-start target ramp.
   input wire logic drop_in, // Bench request: output collapses.
   output logic rise_out, // Feedback above the rising threshold.
   output logic fall_out // Feedback below the falling threshold.
);
   // Output follows the ramp; thresholds sit near 90 and 86.5 percent of full.
   // Hysteresis leaves both comparators low between the two thresholds.
   always_comb begin
      rise_out = boost_on_in && !drop_in && (ramp_in >= 8'hE6);
      fall_out = !boost_on_in || drop_in || (ramp_in < 8'hDD);
   end
endmodule
`default_nettype wire

// ==== lbf_top_tb.sv ====
// Self-checking testbench for the backlight fade, blink and boost control block.
`timescale 1ns/10ps
`default_nettype none
module lbf_top_tb;
   localparam int DG = 20;
   logic clk = 1'h0, rst = 1'h1, mode = 1'h0, ben = 1'h0, mask = 1'h0, drop = 1'h0;
   logic bl = 1'h0, bl_wr = 1'h0, ovr = 1'h0, en_wr = 1'h0;
   logic [1:0] ovp = 2'h0;
   logic [5:0] code = 6'h00;
   logic [3:0] fi = 4'h0, fo = 4'h0, grp = 4'h0, en = 4'h0;
   logic [23:0] ccode = 24'h000000;
   logic [11:0] ton = 12'h000, toff = 12'h000;
   logic fb_rise, fb_fall, b_on, ss_on, pg_st, pg_pin;
   logic [7:0] ramp;
   logic [1:0] ovp_o;
   logic [29:0] lvl;
   logic [74:0] ua;
   logic [2:0] bact;
   int num_errors = 0, n_checks = 0, n, on_n, mis;
   // Short counts keep the run brief; every expectation uses these values.
   lbf_top #(.DEGLITCH_CYC(DG), .SS_STEP_CYC(2), .FADE_UNIT_CYC(3),
      .BLINK_UNIT_CYC(10)) uut (
      .CLK_IN(clk), .SYS_RST_IN(rst), .BOOST_MODE_SELECT_IN(mode),
      .BOOST_STANDALONE_ENABLE_IN(ben), .BOOST_OVERVOLTAGE_SELECT_IN(ovp),
      .BOOST_GOOD_ROUTE_MASK_IN(mask), .FB_GOOD_RISE_IN(fb_rise), .FB_LOW_FALL_IN(fb_fall),
      .BACKLIGHT_CURRENT_CODE_IN(code), .BACKLIGHT_ENABLE_IN(bl),
      .BACKLIGHT_ENABLE_WR_IN(bl_wr), .FADE_IN_RATE_IN(fi), .FADE_OUT_RATE_IN(fo),
      .FADE_OVERRIDE_ENABLE_IN(ovr), .CHANNEL_GROUP_SELECT_IN(grp),
      .LED_CHANNEL_ENABLE_IN(en), .LED_CHANNEL_ENABLE_WR_IN(en_wr),
      .CHANNEL_CODE_IN(ccode), .BLINK_ON_TIMER_IN(ton), .BLINK_OFF_TIMER_IN(toff),
      .BOOST_ON_OUT(b_on), .BOOST_SOFT_START_OUT(ss_on), .BOOST_RAMP_OUT(ramp),
      .BOOST_OVP_SEL_OUT(ovp_o), .BOOST_GOOD_STATUS_OUT(pg_st),
      .POWER_GOOD_PIN_OUT(pg_pin), .SINK_LEVEL_OUT(lvl), .SINK_CURRENT_UA_OUT(ua),
      .BLINK_ACTIVE_OUT(bact));
   // Comparators see the ramp the block commands.
   lbf_fb_model fbm (.boost_on_in(b_on), .ramp_in(ramp), .drop_in(drop),
      .rise_out(fb_rise), .fall_out(fb_fall));
   // 200 MHz timebase.
   always #2.5 clk = ~clk;
   // Inputs move only at falling edges, clear of the sampling edge.
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // Write pulses last one cycle; the level holds afterwards.
   task automatic set_bl(input logic v);
      bl = v;
      bl_wr = 1'h1;
      tick(1);
      bl_wr = 1'h0;
   endtask
   task automatic set_en(input logic [3:0] v);
      en = v;
      en_wr = 1'h1;
      tick(1);
      en_wr = 1'h0;
   endtask
   task automatic conclude;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      tick(16);
      rst = 1'h0;
      tick(1);
      chk(lvl, 32'h0);
      chk({b_on, pg_pin, pg_st}, 32'h0);
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 4; k++) begin
            mode = m[0];
            ovp = k[1:0];
            tick(1);
            chk(ovp_o, k[1:0]);
         end
      end
      // Standalone: sinks must stay dark whatever the host asks.
      code = 6'h3F;
      set_bl(1'h1);
      ccode = 24'hFFFFFF;
      set_en(4'hF);
      tick(2);
      chk(lvl, 32'h0);
      chk(b_on, 1'h0);
      ben = 1'h1;
      tick(1);
      chk(b_on, 1'h1);
      tick(1);
      chk(ss_on, 1'h1);
      n = 0;
      while (ss_on === 1'h1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk(ramp, 8'hFF);
      chk(n >= 505 && n <= 515, 1'h1);
      chk({pg_st, pg_pin}, 2'h2);
      mask = 1'h1;
      tick(1);
      chk(pg_pin, 1'h1);
      drop = 1'h1;
      tick(1);
      chk({pg_st, pg_pin}, 2'h0);
      drop = 1'h0;
      tick(DG - 3);
      chk(pg_st, 1'h0);
      tick(5);
      chk({pg_st, pg_pin}, 2'h3);
      // LED mode: the enable bit no longer starts the boost.
      set_bl(1'h0);
      set_en(4'h0);
      mode = 1'h0;
      tick(3);
      chk({b_on, pg_pin}, 2'h0);
      set_bl(1'h1);
      chk(lvl[5:0], 6'h3F);
      tick(1);
      chk(b_on, 1'h1);
      chk(ua[14:0], 15'h4E20);
      code = 6'h0A;
      tick(2);
      chk(ua[14:0], 15'h01F7);
      // Grouping: ch2 follows ch1, ungrouped ch3 uses its own settings.
      grp = 4'h1;
      ccode = 24'h0001C0;
      set_en(4'h2);
      tick(1);
      chk(lvl[17:6], 12'h1CA);
      set_bl(1'h0);
      tick(1);
      chk(lvl[23:0], 24'h007000);
      // Fade in at 0.3 s and out at 0.6 s full swing, to code 4.
      set_en(4'h0);
      fi = 4'h1;
      fo = 4'h2;
      code = 6'h04;
      tick(1);
      set_bl(1'h1);
      n = 1;
      while (lvl[5:0] !== 6'h04 && n < 400) begin
         tick(1);
         n++;
      end
      chk(n >= 33 && n <= 39, 1'h1);
      set_bl(1'h0);
      n = 1;
      while (lvl[5:0] !== 6'h00 && n < 400) begin
         tick(1);
         n++;
      end
      chk(n >= 69 && n <= 75, 1'h1);
      // Slowest rate from rest still fades; a rewrite mid-fade jumps to target.
      fi = 4'hF;
      code = 6'h3F;
      ovr = 1'h1;
      set_bl(1'h1);
      tick(300);
      chk(lvl[5:0] !== 6'h00 && lvl[5:0] !== 6'h3F, 1'h1);
      set_bl(1'h1);
      chk(lvl[5:0], 6'h3F);
      fi = 4'h0;
      fo = 4'h0;
      tick(1);
      set_bl(1'h0);
      ovr = 1'h0;
      // Blink: ch3 and ch4 one unit on, one off; grouped ch5 ignores its timers.
      grp = 4'h8;
      ccode = 24'h041240;
      ton = 12'h011;
      toff = 12'h211;
      tick(2);
      chk(bact, 3'h3);
      set_en(4'h6);
      on_n = 0;
      mis = 0;
      for (int c = 0; c < 60; c++) begin
         tick(1);
         on_n += (lvl[17:12] !== 6'h00);
         mis += ((lvl[17:12] !== 6'h00) != (lvl[23:18] !== 6'h00));
      end
      chk(mis, 32'h0);
      chk(on_n >= 28 && on_n <= 32, 1'h1);
      chk(lvl[29:24], 6'h00);
      conclude();
   end
   // Whole sequence needs about 1050 cycles; this cuts a hang short.
   initial begin
      #50000;
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
